// file: rtl/hia_flag_if.sv
// Interface between the register slave and the pending-flag store
// Assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface hia_flag_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] flags;
  logic read_clear;
  modport store (output flags, input read_clear);
  modport user (input flags, output read_clear);
endinterface

// file: rtl/hia_flag_store.sv
// Clear-on-read pending flags, one per event source
// Assumes event pulses are already in the pclk domain
`timescale 1ns/10ps
`include "hia_params.svh"
module hia_flag_store #(
  parameter int WIDTH = `HIA_SRC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] events,
  hia_flag_if.store fl
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;
  // Read clears, new event wins over the clear
  always_comb begin
    flags_nxt = flags_r;
    if (fl.read_clear) begin
      flags_nxt = '0;
    end
    flags_nxt = flags_nxt | events;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `HIA_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end
  assign fl.flags = flags_r;
endmodule

// file: rtl/hia_params.svh
// Register offsets, field positions and reset values of the interrupt aggregator
// Assumes inclusion by bare name from the design files
`ifndef HIA_PARAMS_SVH
`define HIA_PARAMS_SVH
`define HIA_ADDR_FLAGS 12'h000
`define HIA_ADDR_EN 12'h004
`define HIA_ADDR_MASK 12'h008
`define HIA_ADDR_PINCFG 12'h00c
`define HIA_FLAGS_RST 8'h00
`define HIA_MASK_RST 8'h00
`define HIA_EN_RST 1'b0
`define HIA_PP_RST 1'b0
`define HIA_EN_BIT 0
`define HIA_PP_BIT 0
`define HIA_ADDR_W 12
`define HIA_SRC_W 8
`endif

// file: rtl/hia_pkg.sv
// Types shared by the interrupt aggregator files
// Assumes nothing of its surroundings
package hia_pkg;
  typedef enum logic [1:0] {
    HIA_REG_FLAGS,
    HIA_REG_EN,
    HIA_REG_MASK,
    HIA_REG_PINCFG
  } hia_reg_type;
endpackage

// file: rtl/hia_top.sv
// Host interrupt aggregator: eight event sources, mask, enable, open-drain or push-pull pin
// Assumes APB master on pclk, event inputs are one-cycle or level signals on pclk
`timescale 1ns/10ps
`include "hia_params.svh"
module hia_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`HIA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sense_conversion_done,
  input wire logic cmd_queue_flag,
  input wire logic cmd_queue_drained,
  input wire logic playback_ended,
  input wire logic sound_ended,
  input wire logic tag_changed,
  input wire logic touch_detected,
  input wire logic swap_done,
  output logic irq_n_o,
  output logic irq_n_oe
);

  // Link to the flag store
  hia_flag_if #(.WIDTH(`HIA_SRC_W)) fl ();

  // Event vector and masked pending bits
  logic [`HIA_SRC_W-1:0] events;
  logic [`HIA_SRC_W-1:0] masked;

  // Mask register
  logic [`HIA_SRC_W-1:0] mask_r;
  logic [`HIA_SRC_W-1:0] mask_nxt;

  // Output enable register
  logic en_r;
  logic en_nxt;

  // Drive mode register, 1 selects push-pull
  logic pp_r;
  logic pp_nxt;

  // Read data register
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Slave error register
  logic slverr_r;
  logic slverr_nxt;

  // Bus phases
  logic setup;
  logic access;

  // Address decode
  logic hit;
  hia_pkg::hia_reg_type sel;

  // Register strobes
  logic wr_en;
  logic wr_mask;
  logic wr_pincfg;
  logic rd_flags;

  // Write data fields
  logic wd_en;
  logic wd_pp;
  logic [`HIA_SRC_W-1:0] wd_mask;

  // Pending summary and pin drive
  logic pend_any;
  logic drive_low;
  logic drive_high;

  // True when the address names one of the four registers
  function automatic logic addr_hit(input logic [`HIA_ADDR_W-1:0] a);
    case (a)
      `HIA_ADDR_FLAGS,
      `HIA_ADDR_EN,
      `HIA_ADDR_MASK,
      `HIA_ADDR_PINCFG: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Register named by an address, flags when unmapped
  function automatic hia_pkg::hia_reg_type addr_sel(input logic [`HIA_ADDR_W-1:0] a);
    case (a)
      `HIA_ADDR_EN: addr_sel = hia_pkg::HIA_REG_EN;
      `HIA_ADDR_MASK: addr_sel = hia_pkg::HIA_REG_MASK;
      `HIA_ADDR_PINCFG: addr_sel = hia_pkg::HIA_REG_PINCFG;
      default: addr_sel = hia_pkg::HIA_REG_FLAGS;
    endcase
  endfunction

  // Read word of one register, unused upper bits zero
  function automatic logic [31:0] read_word(
    input hia_pkg::hia_reg_type r,
    input logic [`HIA_SRC_W-1:0] flags,
    input logic [`HIA_SRC_W-1:0] mask,
    input logic en,
    input logic pp
  );
    read_word = 32'h0000_0000;
    // Flags are returned as they stand at the setup edge
    case (r)
      hia_pkg::HIA_REG_FLAGS: read_word[`HIA_SRC_W-1:0] = flags;
      hia_pkg::HIA_REG_EN: read_word[`HIA_EN_BIT] = en;
      hia_pkg::HIA_REG_MASK: read_word[`HIA_SRC_W-1:0] = mask;
      hia_pkg::HIA_REG_PINCFG: read_word[`HIA_PP_BIT] = pp;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // Source order in the flag word
  assign events = {sense_conversion_done, cmd_queue_flag, cmd_queue_drained, playback_ended,
                   sound_ended, tag_changed, touch_detected, swap_done};

  // Pending flags, set by events and cleared by reads
  hia_flag_store #(.WIDTH(`HIA_SRC_W)) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .fl(fl)
  );

  // Bus phases and address decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit = addr_hit(paddr);
  assign sel = addr_sel(paddr);

  // Write and read strobes per register, active in the access phase
  always_comb begin
    // Idle outside an access of a mapped register
    wr_en = 1'b0;
    wr_mask = 1'b0;
    wr_pincfg = 1'b0;
    rd_flags = 1'b0;

    if (access && hit) begin
      case (sel)
        hia_pkg::HIA_REG_FLAGS: rd_flags = !pwrite;
        hia_pkg::HIA_REG_EN: wr_en = pwrite;
        hia_pkg::HIA_REG_MASK: wr_mask = pwrite;
        hia_pkg::HIA_REG_PINCFG: wr_pincfg = pwrite;
        default: ;
      endcase
    end
  end

  // Clearing read of the flags
  assign fl.read_clear = rd_flags;

  // Write data fields
  assign wd_en = pwdata[`HIA_EN_BIT];
  assign wd_pp = pwdata[`HIA_PP_BIT];
  assign wd_mask = pwdata[`HIA_SRC_W-1:0];

  // Zero-wait slave, answer from registers
  assign pready = 1'b1;
  assign pslverr = slverr_r;
  assign prdata = prdata_r;

  // Per-source gating of pending flags by the mask
  genvar gi;
  generate
    for (gi = 0; gi < `HIA_SRC_W; gi++) begin : g_mask
      assign masked[gi] = fl.flags[gi] & mask_r[gi];
    end
  endgenerate

  // Mask next value
  always_comb begin
    // Hold unless written
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = wd_mask;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // All sources blocked after reset
      mask_r <= `HIA_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Output enable next value
  always_comb begin
    // Hold unless written
    en_nxt = en_r;
    if (wr_en) begin
      en_nxt = wd_en;
    end
  end

  // Output enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pin released after reset
      en_r <= `HIA_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // Drive mode next value
  always_comb begin
    // Hold unless written
    pp_nxt = pp_r;
    if (wr_pincfg) begin
      pp_nxt = wd_pp;
    end
  end

  // Drive mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Open-drain after reset
      pp_r <= `HIA_PP_RST;
    end else begin
      pp_r <= pp_nxt;
    end
  end

  // Read data captured at the setup edge of a read, held until the next read setup
  always_comb begin
    // Hold between read setups
    prdata_nxt = prdata_r;

    if (setup && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      if (hit) begin
        prdata_nxt = read_word(sel, fl.flags, mask_r, en_r, pp_r);
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Bus reads zero after reset
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Error flag: decided at setup, held through the access phase
  always_comb begin
    // Clear outside a transfer
    slverr_nxt = 1'b0;

    if (setup) begin
      slverr_nxt = !hit;
    end else if (access) begin
      slverr_nxt = slverr_r;
    end
  end

  // Slave error register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // No error after reset
      slverr_r <= 1'b0;
    end else begin
      slverr_r <= slverr_nxt;
    end
  end

  // Any unmasked pending flag
  assign pend_any = |masked;

  // Low drive when enabled and something is pending
  assign drive_low = en_r && pend_any;

  // High drive only in push-pull mode while enabled and idle
  assign drive_high = en_r && pp_r && !pend_any;

  // Pin value: low only while asserting
  assign irq_n_o = !drive_low;

  // Enable: open-drain drives only the low level
  assign irq_n_oe = drive_low || drive_high;
endmodule

// file: sim/hia_chk_props.sv
// Port assertions for the aggregator
// Bound onto hia_top, sees its ports only
`timescale 1ns/10ps
module hia_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic irq_n_o,
  input logic irq_n_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, bad;
  // Access phase and unmapped decode
  assign acc = psel && penable;
  assign bad = |{paddr[11:4], paddr[1:0]};
  a_pin_float: assert property (!irq_n_oe |-> irq_n_o) else $error("low undriven");
  a_low_driven: assert property (!irq_n_o |-> irq_n_oe) else $error("low not driven");
  a_ready_high: assert property (pready) else $error("not ready");
  a_bad_err: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped");
  a_good_ok: assert property (acc && !bad |-> !pslverr) else $error("false error");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_hold_low: assert property (!irq_n_o && !acc |=> !irq_n_o) else $error("released");
  a_rise_cause: assert property ($rose(irq_n_o) |-> $past(acc)) else $error("no access");
endmodule
bind hia_top hia_chk u_chk (.*);

// file: sim/hia_host_model.sv
// Host end of the interrupt line
// Assumes the split pin value and enable
`timescale 1ns/10ps
module hia_host_model (
  input logic irq_n_o,
  input logic irq_n_oe,
  output logic irq_line
);
  // Pull-up wins when nothing drives
  assign irq_line = irq_n_oe ? irq_n_o : 1'h1;
endmodule

// file: sim/testbench.sv
// APB register and event tests
// Assumes design, checker and host model compiled
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic qerr;
  logic pready, pslverr, irq_n_o, irq_n_oe, irq_line;
  logic [7:0] ev = 8'h0;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 pclk = ~pclk;
  hia_top u_hia_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_conversion_done(ev[7]), .cmd_queue_flag(ev[6]), .cmd_queue_drained(ev[5]),
    .playback_ended(ev[4]), .sound_ended(ev[3]), .tag_changed(ev[2]), .touch_detected(ev[1]),
    .swap_done(ev[0]), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  hia_host_model u_hia_host_model (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
  task give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, then an idle cycle
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    qerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task pulse(input logic [7:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 8'h0;
    @(posedge pclk);
  endtask
  // Cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rw(1'h0, 12'(4 * i), 32'h0);
      chk("reset", q, 32'h0);
    end
    rw(1'h0, 12'h010, 32'h0);
    chk("unmapped", {q[30:0], qerr}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk("pin off", irq_line, 1'h1);
      rw(1'h0, 12'h000, 32'h0);
      chk("flag", q, 32'h1 << i);
    end
    rw(1'h0, 12'h000, 32'h0);
    chk("cleared", q, 32'h0);
    rw(1'h1, 12'h004, 32'h1);
    rw(1'h1, 12'h008, 32'h1);
    pulse(8'h02);
    chk("masked", irq_line, 1'h1);
    pulse(8'h01);
    chk("asserted", {irq_line, irq_n_oe}, 2'h1);
    rw(1'h0, 12'h000, 32'h0);
    chk("open drain", {q[7:0], irq_line, irq_n_oe}, 10'h00e);
    rw(1'h1, 12'h00c, 32'h1);
    chk("push pull", irq_n_oe, 1'h1);
    // Event lands on the clearing edge
    fork
      rw(1'h0, 12'h000, 32'h0);
      begin
        @(posedge pclk);
        ev <= 8'h20;
        @(posedge pclk);
        ev <= 8'h0;
      end
    join
    rw(1'h0, 12'h000, 32'h0);
    chk("race", q, 32'h20);
    give_verdict;
  end
endmodule
